// ### casbx_exec.sv
`timescale 1ns/1ns
module casbx_exec (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic OP_VALID,                      // decoder offers an op
    input wire casbx_pkg::casbx_op_t OP_CODE,       // operation to run
    input wire logic [casbx_pkg::FADDR_W-1:0] OP_FILE, // file address
    input wire logic OP_DEST,                       // 0 acc, 1 file
    input wire logic [casbx_pkg::BSEL_W-1:0] OP_BIT, // bit select
    input wire logic [casbx_pkg::LIT_W-1:0] OP_LIT, // signed literal
    input wire logic [casbx_pkg::DATA_W-1:0] FILE_RDATA, // addressed file
    output logic OP_READY,                          // low in the nop slot
    output logic FILE_WE,                           // file write pulse
    output logic [casbx_pkg::FADDR_W-1:0] FILE_WADDR, // write address
    output logic [casbx_pkg::DATA_W-1:0] FILE_WDATA, // write data
    output logic [casbx_pkg::DATA_W-1:0] ACC,       // accumulator
    output logic SPILL,                             // carry flag
    output logic HALF_FLAG,                         // digit carry flag
    output logic NULL_FLAG,                         // zero flag
    output logic [casbx_pkg::PC_W-1:0] PC,          // program counter
    output logic FLUSH                              // fetched op discarded
);
    import casbx_pkg::*;

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        logic rst_meta;               // reset sync stage 1
        logic rst_ok;                 // reset sync stage 2
        logic nop_slot;               // second cycle running as nop
        logic ready;                  // taking ops; low in nop slot, reset
        logic we;                     // file write strobe
        logic [FADDR_W-1:0] waddr;    // file write address
        logic [DATA_W-1:0] wdata;     // file write data
        logic [DATA_W-1:0] acc;       // accumulator
        logic spill;                  // carry
        logic half;                   // digit carry
        logic nul;                    // zero
        logic [PC_W-1:0] pc;          // program counter
        logic flush;                  // discard pulse
    } casbx_state_t;

    casbx_state_t st_reg;   // registered state
    casbx_state_t st_next;  // next state

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // 9-bit add result: bit 8 spill, bit HALF_BIT of nibble sum is half
    function automatic logic [DATA_W:0] add9(input logic [DATA_W-1:0] a,
            input logic [DATA_W-1:0] b, input logic ci);
        add9 = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, ci};
    endfunction : add9

    function automatic logic half_of(input logic [DATA_W-1:0] a,
            input logic [DATA_W-1:0] b, input logic ci);
        logic [HALF_BIT:0] s;
        s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        half_of = s[HALF_BIT];
    endfunction : half_of

    // ------------------------------------------------------------
    // reset release: async assert, sync release
    // ------------------------------------------------------------
    logic rst_n;
    assign rst_n = st_reg.rst_ok;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [DATA_W:0] sum;          // adder result
        logic [DATA_W-1:0] res;        // data result
        logic wr_res;                  // result goes to a destination
        logic [PC_W-1:0] pc_inc;       // already incremented counter
        logic tbit;                    // tested bit
        sum = '0;
        res = '0;
        wr_res = 1'b0;
        tbit = FILE_RDATA[OP_BIT];
        pc_inc = st_reg.pc + 15'h0001;
        st_next = st_reg;
        st_next.rst_meta = 1'b1;
        st_next.rst_ok = st_reg.rst_meta;
        st_next.we = 1'b0;
        st_next.flush = 1'b0;
        if (st_reg.nop_slot) begin
            // discarded slot behaves as nop: only the pc advances
            st_next.nop_slot = 1'b0;
            st_next.pc = pc_inc;
        end else if (OP_VALID && st_reg.ready) begin
            st_next.pc = pc_inc;
            case (OP_CODE)
                OP_SUM_ACC_INTO_FILE, OP_SUM_ACC_FILE_SPILL: begin
                    // plain add uses carry-in 0, spill variant the flag
                    sum = add9(st_reg.acc, FILE_RDATA,
                        (OP_CODE == OP_SUM_ACC_FILE_SPILL) & st_reg.spill);
                    res = sum[DATA_W-1:0];
                    st_next.spill = sum[DATA_W];
                    st_next.half = half_of(st_reg.acc, FILE_RDATA,
                        (OP_CODE == OP_SUM_ACC_FILE_SPILL) & st_reg.spill);
                    st_next.nul = (res == 8'h00);
                    wr_res = 1'b1;
                end
                OP_SIGNED_RIGHT_SHIFT: begin
                    res = {FILE_RDATA[7], FILE_RDATA[7:1]};
                    st_next.spill = FILE_RDATA[0];
                    st_next.nul = (res == 8'h00);
                    wr_res = 1'b1;
                end
                OP_BIT_CLEAR: begin
                    // flags left alone, always written back to file
                    res = FILE_RDATA;
                    res[OP_BIT] = 1'b0;
                    st_next.we = 1'b1;
                    st_next.waddr = OP_FILE;
                    st_next.wdata = res;
                end
                OP_TEST_SKIP_ZERO: begin
                    if (!tbit) begin
                        st_next.nop_slot = 1'b1;
                        st_next.flush = 1'b1;
                    end
                end
                OP_TEST_SKIP_ONE: begin
                    if (tbit) begin
                        st_next.nop_slot = 1'b1;
                        st_next.flush = 1'b1;
                    end
                end
                OP_LITERAL_JUMP: begin
                    // sign-extend the literal; wraps across the pc width
                    st_next.pc = pc_inc
                        + {{(PC_W-LIT_W){OP_LIT[LIT_W-1]}}, OP_LIT};
                    st_next.nop_slot = 1'b1;
                    st_next.flush = 1'b1;
                end
                OP_ACC_JUMP: begin
                    st_next.pc = pc_inc
                        + {{(PC_W-DATA_W){1'b0}}, st_reg.acc};
                    st_next.nop_slot = 1'b1;
                    st_next.flush = 1'b1;
                end
                default: begin
                    // unlisted op: counter advances only
                end
            endcase
            if (wr_res) begin
                if (OP_DEST) begin
                    st_next.we = 1'b1;
                    st_next.waddr = OP_FILE;
                    st_next.wdata = res;
                end else begin
                    st_next.acc = res;
                end
            end
        end
        // registered so the ready pin needs no gate behind the flop
        st_next.ready = ~st_next.nop_slot;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_reg <= '0;
            st_reg.pc <= PC_RESET;
            st_reg.acc <= ACC_RESET;
        end else if (!rst_n) begin
            // sync chain keeps running while the rest holds reset
            st_reg <= '0;
            st_reg.pc <= PC_RESET;
            st_reg.acc <= ACC_RESET;
            st_reg.rst_meta <= 1'b1;
            st_reg.rst_ok <= st_reg.rst_meta;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flip-flops
    // ------------------------------------------------------------
    assign OP_READY = st_reg.ready;
    assign FILE_WE = st_reg.we;
    assign FILE_WADDR = st_reg.waddr;
    assign FILE_WDATA = st_reg.wdata;
    assign ACC = st_reg.acc;
    assign SPILL = st_reg.spill;
    assign HALF_FLAG = st_reg.half;
    assign NULL_FLAG = st_reg.nul;
    assign PC = st_reg.pc;
    assign FLUSH = st_reg.flush;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic go;
    assign go = OP_VALID & OP_READY;

    a_add_spill_out: assert property (@(posedge CLK) disable iff (!rst_n)
        go && OP_CODE == OP_SUM_ACC_INTO_FILE && !OP_DEST |=>
        {SPILL, ACC} == {1'b0, $past(ACC)} + {1'b0, $past(FILE_RDATA)})
        else $error("add result wrong");
    a_dest_file_write: assert property (@(posedge CLK) disable iff (!rst_n)
        go && OP_DEST && (OP_CODE == OP_SUM_ACC_INTO_FILE
        || OP_CODE == OP_SIGNED_RIGHT_SHIFT) |=> FILE_WE
        && FILE_WADDR == $past(OP_FILE) && $stable(ACC))
        else $error("file destination not written");
    a_shift_msb_kept: assert property (@(posedge CLK) disable iff (!rst_n)
        go && OP_CODE == OP_SIGNED_RIGHT_SHIFT && !OP_DEST |=>
        ACC == {$past(FILE_RDATA[7]), $past(FILE_RDATA[7:1])}
        && SPILL == $past(FILE_RDATA[0]))
        else $error("shift wrong");
    a_addc_spill_in: assert property (@(posedge CLK) disable iff (!rst_n)
        go && OP_CODE == OP_SUM_ACC_FILE_SPILL && !OP_DEST |=>
        ACC == 8'($past(ACC) + $past(FILE_RDATA) + 8'($past(SPILL))))
        else $error("add with spill wrong");
    a_clear_bit_only: assert property (@(posedge CLK) disable iff (!rst_n)
        go && OP_CODE == OP_BIT_CLEAR |=> FILE_WE
        && FILE_WDATA == ($past(FILE_RDATA) & ~(8'h01 << $past(OP_BIT)))
        && $stable(SPILL) && $stable(NULL_FLAG) && $stable(HALF_FLAG))
        else $error("bit clear wrong");
    a_skip_zero_nop: assert property (@(posedge CLK) disable iff (!rst_n)
        go && OP_CODE == OP_TEST_SKIP_ZERO |=>
        (FLUSH && !OP_READY) == !$past(FILE_RDATA[OP_BIT]))
        else $error("skip on zero wrong");
    a_skip_one_nop: assert property (@(posedge CLK) disable iff (!rst_n)
        go && OP_CODE == OP_TEST_SKIP_ONE |=> FLUSH == $past(FILE_RDATA[OP_BIT])
        && $stable(SPILL) && $stable(NULL_FLAG))
        else $error("skip on one wrong");
    a_lit_jump_pc: assert property (@(posedge CLK) disable iff (!rst_n)
        go && OP_CODE == OP_LITERAL_JUMP |=> PC == 15'($past(PC) + 15'h0001
        + {{6{$past(OP_LIT[8])}}, $past(OP_LIT)}) ##1 OP_READY)
        else $error("literal jump wrong");
    a_acc_jump_pc: assert property (@(posedge CLK) disable iff (!rst_n)
        go && OP_CODE == OP_ACC_JUMP |=> PC == 15'($past(PC) + 15'h0001
        + {7'h00, $past(ACC)}) && !OP_READY && $stable(SPILL))
        else $error("acc jump wrong");
    a_null_on_zero: assert property (@(posedge CLK) disable iff (!rst_n)
        go && !OP_DEST && (OP_CODE == OP_SUM_ACC_INTO_FILE
        || OP_CODE == OP_SUM_ACC_FILE_SPILL) |=> NULL_FLAG == (ACC == 8'h00))
        else $error("null flag wrong");
endmodule : casbx_exec

// ### casbx_pkg.sv
package casbx_pkg;
    // ------------------------------------------------------------
    // operation codes presented by the decoder
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE,                  // idle slot, only the counter advances
        OP_SUM_ACC_INTO_FILE,     // acc + file
        OP_SUM_ACC_FILE_SPILL,    // acc + file + spill
        OP_SIGNED_RIGHT_SHIFT,    // msb kept, lsb to spill
        OP_BIT_CLEAR,             // one file bit forced low
        OP_TEST_SKIP_ZERO,        // skip next when bit is 0
        OP_TEST_SKIP_ONE,         // skip next when bit is 1
        OP_LITERAL_JUMP,          // pc + 1 + signed literal
        OP_ACC_JUMP               // pc + 1 + unsigned acc
    } casbx_op_t;

    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int DATA_W = 8;      // data path width
    localparam int FADDR_W = 7;     // file address 0..127
    localparam int BSEL_W = 3;      // bit select 0..7
    localparam int LIT_W = 9;       // signed jump literal
    localparam int PC_W = 15;       // program counter width
    localparam int HALF_BIT = 4;    // carry out of bit 3 lands here
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
endpackage : casbx_pkg

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import casbx_pkg::*;
    // ------------------------------------------------------------
    // stimulus, observed outputs and the bench's own core model
    // ------------------------------------------------------------
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic op_valid = 1'h0;
    casbx_op_t op_code = OP_NONE;
    logic [FADDR_W-1:0] op_file = 7'h00;
    logic op_dest = 1'h0;
    logic [BSEL_W-1:0] op_bit = 3'h0;
    logic [LIT_W-1:0] op_lit = 9'h000;
    logic [DATA_W-1:0] file_rdata = 8'h00;
    logic op_ready, file_we, spill, half_flag, null_flag, flush;
    logic [FADDR_W-1:0] file_waddr;
    logic [DATA_W-1:0] file_wdata, acc;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] m_acc = ACC_RESET; // expected accumulator
    logic m_c = 1'h0, m_h = 1'h0, m_z = 1'h0; // expected flags
    logic [PC_W-1:0] m_pc = PC_RESET; // expected counter
    int fails = 0, cmp_count = 0, cycles = 0, i;
    always #4 clk = ~clk;
    casbx_exec u_dut (.CLK(clk), .ARST_N(arst_n), .OP_VALID(op_valid),
        .OP_CODE(op_code), .OP_FILE(op_file), .OP_DEST(op_dest),
        .OP_BIT(op_bit), .OP_LIT(op_lit), .FILE_RDATA(file_rdata),
        .OP_READY(op_ready), .FILE_WE(file_we), .FILE_WADDR(file_waddr),
        .FILE_WDATA(file_wdata), .ACC(acc), .SPILL(spill),
        .HALF_FLAG(half_flag), .NULL_FLAG(null_flag), .PC(pc),
        .FLUSH(flush));
    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    // hang guard: whole run needs about 110 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // one decoder op: model the outcome, offer it, check the answer
    // ------------------------------------------------------------
    task automatic run_op(input casbx_op_t code, input logic [6:0] f,
            input logic d, input logic [2:0] b, input logic [8:0] k,
            input logic [7:0] rd);
        logic [8:0] sum;
        logic [4:0] nib;
        logic [7:0] res;
        logic cin, we, fl;
        logic [PC_W-1:0] npc;
        res = m_acc;
        we = 1'h0;
        fl = 1'h0;
        npc = m_pc + 15'h0001;
        cin = (code == OP_SUM_ACC_FILE_SPILL) & m_c;
        case (code)
            OP_SUM_ACC_INTO_FILE, OP_SUM_ACC_FILE_SPILL: begin
                sum = {1'h0, m_acc} + {1'h0, rd} + {8'h00, cin};
                nib = {1'h0, m_acc[3:0]} + {1'h0, rd[3:0]} + {4'h0, cin};
                res = sum[7:0];
                m_c = sum[8];
                m_h = nib[4];
            end
            OP_SIGNED_RIGHT_SHIFT: begin
                res = {rd[7], rd[7:1]};
                m_c = rd[0];
            end
            OP_BIT_CLEAR: begin
                res = rd & ~(8'h01 << b);
                we = 1'h1;
            end
            OP_TEST_SKIP_ZERO: fl = ~rd[b];
            OP_TEST_SKIP_ONE: fl = rd[b];
            OP_LITERAL_JUMP: begin
                npc = m_pc + 15'h0001 + {{6{k[8]}}, k};
                fl = 1'h1;
            end
            OP_ACC_JUMP: begin
                npc = m_pc + 15'h0001 + {7'h00, m_acc};
                fl = 1'h1;
            end
            default: ;
        endcase
        if (code inside {OP_SUM_ACC_INTO_FILE, OP_SUM_ACC_FILE_SPILL,
                OP_SIGNED_RIGHT_SHIFT}) begin
            m_z = (res == 8'h00);
            if (d) we = 1'h1;
            else m_acc = res;
        end
        @(posedge clk);
        op_valid <= 1'h1;
        op_code <= code;
        op_file <= f;
        op_dest <= d;
        op_bit <= b;
        op_lit <= k;
        file_rdata <= rd;
        #1;
        // hold the offer through any nop slot still pending
        while (op_ready !== 1'h1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        op_valid <= 1'h0;
        #1;
        chk(acc, m_acc);
        chk(spill, m_c);
        chk(half_flag, m_h);
        chk(null_flag, m_z);
        chk(file_we, we);
        if (we) chk(file_waddr, f);
        if (we) chk(file_wdata, res);
        chk(pc, npc);
        chk(flush, fl);
        chk(op_ready, !fl);
        // the discarded slot still steps the counter
        m_pc = fl ? npc + 15'h0001 : npc;
    endtask : run_op
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        chk(pc, PC_RESET);
        chk(op_ready, 1'h1);
        run_op(OP_SUM_ACC_INTO_FILE, 7'h05, 1'h0, 3'h0, 9'h000, 8'h0f);
        run_op(OP_SUM_ACC_INTO_FILE, 7'h06, 1'h0, 3'h0, 9'h000, 8'h01);
        run_op(OP_SUM_ACC_INTO_FILE, 7'h7f, 1'h1, 3'h0, 9'h000, 8'hf0);
        $display("add test done");
        run_op(OP_SUM_ACC_FILE_SPILL, 7'h10, 1'h0, 3'h0, 9'h000, 8'h00);
        run_op(OP_SIGNED_RIGHT_SHIFT, 7'h11, 1'h1, 3'h0, 9'h000, 8'h81);
        run_op(OP_SUM_ACC_FILE_SPILL, 7'h12, 1'h1, 3'h0, 9'h000, 8'h0e);
        run_op(OP_SIGNED_RIGHT_SHIFT, 7'h13, 1'h0, 3'h0, 9'h000, 8'h02);
        $display("carry and shift test done");
        for (i = 0; i < 8; i++) begin
            run_op(OP_BIT_CLEAR, 7'h20, 1'h1, i[2:0], 9'h000, 8'hff);
        end
        $display("bit clear test done");
        for (i = 0; i < 8; i++) begin
            run_op(OP_TEST_SKIP_ZERO, 7'h30, 1'h0, i[2:0], 9'h000, 8'h01 << i);
            run_op(OP_TEST_SKIP_ZERO, 7'h30, 1'h0, i[2:0], 9'h000, ~(8'h01 << i));
            run_op(OP_TEST_SKIP_ONE, 7'h31, 1'h0, i[2:0], 9'h000, 8'h01 << i);
            run_op(OP_TEST_SKIP_ONE, 7'h31, 1'h0, i[2:0], 9'h000, ~(8'h01 << i));
        end
        $display("skip test done");
        run_op(OP_LITERAL_JUMP, 7'h00, 1'h0, 3'h0, 9'h100, 8'h00);
        run_op(OP_LITERAL_JUMP, 7'h00, 1'h0, 3'h0, 9'h0ff, 8'h00);
        run_op(OP_SUM_ACC_INTO_FILE, 7'h40, 1'h0, 3'h0, 9'h000, 8'hfe);
        run_op(OP_ACC_JUMP, 7'h00, 1'h0, 3'h0, 9'h000, 8'h00);
        run_op(OP_NONE, 7'h00, 1'h0, 3'h0, 9'h000, 8'h00);
        $display("jump test done");
        close_out();
    end
endmodule : tb_top
